//--- core/dcc_cfg.svh
// Register map, field positions and reset values of the comparator control block
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
`define DCC_ADDR_W 2
`define DCC_OFF_A_CTRL 2'h0
`define DCC_OFF_B_CTRL 2'h1
`define DCC_OFF_SYNC 2'h2
`define DCC_BIT_ENABLE 7
`define DCC_BIT_RESULT 6
`define DCC_BIT_PIN_OE 5
`define DCC_BIT_INVERT 4
`define DCC_BIT_SPEED 3
`define DCC_BIT_REF 2
`define DCC_BIT_CH_HI 1
`define DCC_BIT_CH_LO 0
`define DCC_BIT_MIRROR_A 7
`define DCC_BIT_MIRROR_B 6
`define DCC_BIT_SYNC_EN 0
`define DCC_CTRL_RESET 8'h00
`define DCC_SYNC_RESET 1'h0
`define DCC_CH_AN1 2'h0
`define DCC_CH_AN5 2'h1
`define DCC_CH_AN6 2'h2
`define DCC_CH_AN7 2'h3
`define DCC_SYNC_STAGES 2
`endif

//--- core/dcc_pkg.sv
// Types shared by the comparator control block
package dcc_pkg;
  typedef struct packed {
    logic enable;
    logic pin_oe;
    logic invert;
    logic speed;
    logic ref_sel;
    logic [1:0] channel;
  } dcc_ctrl_t;

  typedef enum logic [2:0] {
    DCC_SYNC_IDLE = 3'h1,
    DCC_SYNC_HIGH = 3'h2,
    DCC_SYNC_LOW = 3'h4
  } dcc_tstate_t;
endpackage : dcc_pkg

//--- core/dcc_chan_if.sv
// Per-comparator control and result bundle between the block's modules
`timescale 1ns/1ps
interface dcc_chan_if;
  import dcc_pkg::*;
  dcc_ctrl_t ctrl;
  logic result;
  logic pin_level;
  modport regs (output ctrl, input result, input pin_level);
  modport chan (input ctrl, output result, output pin_level);
endinterface : dcc_chan_if

//--- core/dcc_channel.sv
// One comparator: input gate, polarity and end-of-cycle result latch
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_channel
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic raw_in,
  dcc_chan_if.chan bus
);
  logic gated;
  logic adjusted;
  logic result_ff;
  logic nxt_result;
  logic [`DCC_SYNC_STAGES-1:0] sync_ff;
  logic [`DCC_SYNC_STAGES-1:0] nxt_sync;

  // Analog decision crosses into the clock domain
  always_comb begin
    nxt_sync = {sync_ff[`DCC_SYNC_STAGES-2:0], raw_in};
  end

  always_comb begin
    gated = bus.ctrl.enable & sync_ff[`DCC_SYNC_STAGES-1]; // RULE22 RULE1
    adjusted = gated ^ bus.ctrl.invert; // RULE4 RULE13
    nxt_result = adjusted;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_ff <= '0;
      result_ff <= 1'h0;
    end else begin
      sync_ff <= nxt_sync;
      result_ff <= nxt_result; // RULE7
    end
  end

  assign bus.result = result_ff;
  // Unlatched level for the pin path
  assign bus.pin_level = adjusted; // RULE7
endmodule : dcc_channel

//--- core/dcc_timer_sync.sv
// Samples a level on the falling edge of the synchronised timer clock
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_timer_sync
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic timer_clk_in,
  input wire logic level_in,
  output logic level_out
);
  logic [`DCC_SYNC_STAGES-1:0] tclk_ff;
  logic [`DCC_SYNC_STAGES-1:0] nxt_tclk;
  dcc_tstate_t state_ff;
  dcc_tstate_t nxt_state;
  logic held_ff;
  logic nxt_held;

  always_comb begin
    nxt_tclk = {tclk_ff[`DCC_SYNC_STAGES-2:0], timer_clk_in};
    nxt_state = state_ff;
    nxt_held = held_ff;
    case (state_ff)
      DCC_SYNC_IDLE: begin
        nxt_state = tclk_ff[`DCC_SYNC_STAGES-1] ? DCC_SYNC_HIGH : DCC_SYNC_LOW;
      end
      DCC_SYNC_HIGH: begin
        if (!tclk_ff[`DCC_SYNC_STAGES-1]) begin
          nxt_state = DCC_SYNC_LOW;
          nxt_held = level_in; // RULE15 RULE19
        end
      end
      DCC_SYNC_LOW: begin
        if (tclk_ff[`DCC_SYNC_STAGES-1]) begin
          nxt_state = DCC_SYNC_HIGH;
        end
      end
      default: begin
        nxt_state = DCC_SYNC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tclk_ff <= '0;
      state_ff <= DCC_SYNC_IDLE;
      held_ff <= 1'h0;
    end else begin
      tclk_ff <= nxt_tclk;
      state_ff <= nxt_state;
      held_ff <= nxt_held;
    end
  end

  assign level_out = held_ff;
endmodule : dcc_timer_sync

//--- core/dcc_top.sv
// Register bank and pin control for the dual comparator block
//
// Behaviour
// RULE1: Comparator A runs only while its enable bit 7 is one.
// RULE2: Channel select 00/01/10/11 steers A's inverting input to AN1/5/6/7.
// RULE3: Reference bit 2 picks internal reference (1) or external pin (0).
// RULE4: Result is one when noninverting input is higher; polarity bit 4 inverts.
// RULE5: Polarity-adjusted A result reads at bit 6; writes ignored.
// RULE6: A drives its pin only with bit 5, enable and direction output.
// RULE7: Internal result latched each cycle; pin path is not latched. Here the pin outputs are registered each cycle as well (a_pin_ff, b_pin_ff).
// RULE8: Change events work regardless of pin output enable.
// RULE9: Speed bit 3: one normal speed, zero low power; driven out.
// RULE10: Comparator B control register mirrors A's layout and behaviour.
// RULE11: B reference bit picks its internal reference or its own pin.
// RULE12: B channel select uses the same 00..11 encoding as A.
// RULE13: B result inverted by its polarity bit; read bit shows adjusted.
// RULE14: B drives its pin only with enable, pin enable and port C bit 4 output.
// RULE15: With sync bit set, B result sampled at timer clock falling edge. Here reads stay unsampled; only cmp_b_change and cmp_b_sync_result use it.
// RULE16: One register holds read-only mirrors of both results.
// RULE17: Reading mirrors leaves the mismatch latches untouched.
// RULE18: Mirror A at bit 7, mirror B at bit 6, sync enable bit 0.
// RULE19: Sampling uses the prescaled timer clock falling edge.
// RULE20: Change flags pulse on a mismatch edge, not a level.
// RULE21: Any reset returns all control registers, disabling both comparators.
// RULE22: Raw decision is a one-bit input forced low while disabled.
// RULE23: Both control registers reset to all zeros.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_top
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [`DCC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cmp_a_raw,
  input wire logic cmp_b_raw,
  input wire logic timer_clk_prescaled,
  input wire logic port_a_direction_bit2,
  input wire logic port_c_direction_bit4,
  output logic cmp_a_on,
  output logic cmp_b_on,
  output logic cmp_a_speed_sel,
  output logic cmp_b_speed_sel,
  output logic cmp_a_ref_sel,
  output logic cmp_b_ref_sel,
  output logic [3:0] cmp_a_inv_input_sel,
  output logic [3:0] cmp_b_inv_input_sel,
  output logic cmp_a_pin_out,
  output logic cmp_a_pin_oe,
  output logic cmp_b_pin_out,
  output logic cmp_b_pin_oe,
  output logic cmp_b_sync_result,
  output logic cmp_a_change,
  output logic cmp_b_change
);
  dcc_chan_if a_if ();
  dcc_chan_if b_if ();

  dcc_ctrl_t a_ctrl_ff;
  dcc_ctrl_t nxt_a_ctrl;
  dcc_ctrl_t b_ctrl_ff;
  dcc_ctrl_t nxt_b_ctrl;
  logic sync_en_ff;
  logic nxt_sync_en;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic [1:0] dir_a_ff;
  logic [1:0] nxt_dir_a;
  logic [1:0] dir_c_ff;
  logic [1:0] nxt_dir_c;

  logic b_timed;
  logic b_used;
  logic mis_a_ff;
  logic nxt_mis_a;
  logic mis_b_ff;
  logic nxt_mis_b;
  logic chg_a_ff;
  logic nxt_chg_a;
  logic chg_b_ff;
  logic nxt_chg_b;

  logic [3:0] a_sel_ff;
  logic [3:0] nxt_a_sel;
  logic [3:0] b_sel_ff;
  logic [3:0] nxt_b_sel;
  logic a_pin_ff;
  logic nxt_a_pin;
  logic a_oe_ff;
  logic nxt_a_oe;
  logic b_pin_ff;
  logic nxt_b_pin;
  logic b_oe_ff;
  logic nxt_b_oe;

  // Byte to control fields; the result bit is not writable
  function automatic dcc_ctrl_t dcc_unpack(input logic [7:0] d);
    dcc_ctrl_t c;
    c.enable = d[`DCC_BIT_ENABLE];
    c.pin_oe = d[`DCC_BIT_PIN_OE];
    c.invert = d[`DCC_BIT_INVERT];
    c.speed = d[`DCC_BIT_SPEED];
    c.ref_sel = d[`DCC_BIT_REF];
    c.channel = d[`DCC_BIT_CH_HI:`DCC_BIT_CH_LO];
    return c;
  endfunction : dcc_unpack

  function automatic logic [7:0] dcc_pack(input dcc_ctrl_t c, input logic res);
    logic [7:0] d;
    d = 8'h00;
    d[`DCC_BIT_ENABLE] = c.enable;
    d[`DCC_BIT_RESULT] = res;
    d[`DCC_BIT_PIN_OE] = c.pin_oe;
    d[`DCC_BIT_INVERT] = c.invert;
    d[`DCC_BIT_SPEED] = c.speed;
    d[`DCC_BIT_REF] = c.ref_sel;
    d[`DCC_BIT_CH_HI:`DCC_BIT_CH_LO] = c.channel;
    return d;
  endfunction : dcc_pack

  // One-hot inverting input select: AN1, AN5, AN6, AN7
  function automatic logic [3:0] dcc_ch_decode(input logic [1:0] ch);
    logic [3:0] s;
    s = 4'h0;
    case (ch)
      `DCC_CH_AN1: s = 4'h1;
      `DCC_CH_AN5: s = 4'h2;
      `DCC_CH_AN6: s = 4'h4;
      `DCC_CH_AN7: s = 4'h8;
      default: s = 4'h0;
    endcase
    return s;
  endfunction : dcc_ch_decode

  assign a_if.ctrl = a_ctrl_ff;
  assign b_if.ctrl = b_ctrl_ff;

  dcc_channel u_chan_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .raw_in(cmp_a_raw),
    .bus(a_if)
  );

  dcc_channel u_chan_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .raw_in(cmp_b_raw),
    .bus(b_if)
  );

  dcc_timer_sync u_tsync (
    .clk_sys(clk_sys),
    .reset(reset),
    .timer_clk_in(timer_clk_prescaled),
    .level_in(b_if.result),
    .level_out(b_timed)
  );

  // B result as used by the change logic
  assign b_used = sync_en_ff ? b_timed : b_if.result; // RULE15

  // Register writes and reads
  always_comb begin
    nxt_a_ctrl = a_ctrl_ff;
    nxt_b_ctrl = b_ctrl_ff;
    nxt_sync_en = sync_en_ff;
    nxt_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        `DCC_OFF_A_CTRL: nxt_a_ctrl = dcc_unpack(reg_wdata); // RULE1 RULE5
        `DCC_OFF_B_CTRL: nxt_b_ctrl = dcc_unpack(reg_wdata); // RULE10
        `DCC_OFF_SYNC: nxt_sync_en = reg_wdata[`DCC_BIT_SYNC_EN]; // RULE18
        default: nxt_sync_en = sync_en_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `DCC_OFF_A_CTRL: nxt_rdata = dcc_pack(a_ctrl_ff, a_if.result); // RULE5
        `DCC_OFF_B_CTRL: nxt_rdata = dcc_pack(b_ctrl_ff, b_if.result); // RULE10 RULE13
        `DCC_OFF_SYNC: begin
          nxt_rdata[`DCC_BIT_MIRROR_A] = a_if.result; // RULE16 RULE18
          nxt_rdata[`DCC_BIT_MIRROR_B] = b_if.result; // RULE16 RULE18
          nxt_rdata[`DCC_BIT_SYNC_EN] = sync_en_ff;
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      a_ctrl_ff <= dcc_unpack(`DCC_CTRL_RESET); // RULE21 RULE23
      b_ctrl_ff <= dcc_unpack(`DCC_CTRL_RESET); // RULE21 RULE23
      sync_en_ff <= `DCC_SYNC_RESET; // RULE18
      rdata_ff <= 8'h00;
    end else begin
      a_ctrl_ff <= nxt_a_ctrl;
      b_ctrl_ff <= nxt_b_ctrl;
      sync_en_ff <= nxt_sync_en;
      rdata_ff <= nxt_rdata;
    end
  end

  // Direction pins are synchronised before use
  always_comb begin
    nxt_dir_a = {dir_a_ff[0], port_a_direction_bit2};
    nxt_dir_c = {dir_c_ff[0], port_c_direction_bit4};
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dir_a_ff <= 2'h3;
      dir_c_ff <= 2'h3;
    end else begin
      dir_a_ff <= nxt_dir_a;
      dir_c_ff <= nxt_dir_c;
    end
  end

  // Change detect against mismatch latches; bus reads never touch them
  always_comb begin
    nxt_mis_a = a_if.result; // RULE17
    nxt_mis_b = b_used; // RULE17
    nxt_chg_a = a_if.result ^ mis_a_ff; // RULE20 RULE8
    nxt_chg_b = b_used ^ mis_b_ff; // RULE20 RULE8
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mis_a_ff <= 1'h0;
      mis_b_ff <= 1'h0;
      chg_a_ff <= 1'h0;
      chg_b_ff <= 1'h0;
    end else begin
      mis_a_ff <= nxt_mis_a;
      mis_b_ff <= nxt_mis_b;
      chg_a_ff <= nxt_chg_a;
      chg_b_ff <= nxt_chg_b;
    end
  end

  // Analog steering and pin drive
  always_comb begin
    nxt_a_sel = dcc_ch_decode(a_ctrl_ff.channel); // RULE2
    nxt_b_sel = dcc_ch_decode(b_ctrl_ff.channel); // RULE12
    nxt_a_oe = a_ctrl_ff.pin_oe & a_ctrl_ff.enable & ~dir_a_ff[1]; // RULE6
    nxt_b_oe = b_ctrl_ff.pin_oe & b_ctrl_ff.enable & ~dir_c_ff[1]; // RULE14
    nxt_a_pin = a_if.pin_level; // RULE7
    nxt_b_pin = b_if.pin_level; // RULE7
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      a_sel_ff <= 4'h1;
      b_sel_ff <= 4'h1;
      a_oe_ff <= 1'h0;
      b_oe_ff <= 1'h0;
      a_pin_ff <= 1'h0;
      b_pin_ff <= 1'h0;
    end else begin
      a_sel_ff <= nxt_a_sel;
      b_sel_ff <= nxt_b_sel;
      a_oe_ff <= nxt_a_oe;
      b_oe_ff <= nxt_b_oe;
      a_pin_ff <= nxt_a_pin;
      b_pin_ff <= nxt_b_pin;
    end
  end

  assign reg_rdata = rdata_ff;
  assign cmp_a_on = a_ctrl_ff.enable; // RULE1
  assign cmp_b_on = b_ctrl_ff.enable; // RULE10
  assign cmp_a_speed_sel = a_ctrl_ff.speed; // RULE9
  assign cmp_b_speed_sel = b_ctrl_ff.speed; // RULE9
  assign cmp_a_ref_sel = a_ctrl_ff.ref_sel; // RULE3
  assign cmp_b_ref_sel = b_ctrl_ff.ref_sel; // RULE11
  assign cmp_a_inv_input_sel = a_sel_ff;
  assign cmp_b_inv_input_sel = b_sel_ff;
  assign cmp_a_pin_out = a_pin_ff;
  assign cmp_a_pin_oe = a_oe_ff;
  assign cmp_b_pin_out = b_pin_ff;
  assign cmp_b_pin_oe = b_oe_ff;
  assign cmp_b_sync_result = b_timed;
  assign cmp_a_change = chg_a_ff;
  assign cmp_b_change = chg_b_ff;
endmodule : dcc_top

//--- verif/dcc_assertions.sv
// Port-level checks for the comparator control block
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dcc_assertions (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [`DCC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_clk_prescaled,
  input wire logic cmp_a_on,
  input wire logic cmp_b_on,
  input wire logic cmp_a_speed_sel,
  input wire logic cmp_b_speed_sel,
  input wire logic cmp_a_ref_sel,
  input wire logic cmp_b_ref_sel,
  input wire logic [3:0] cmp_a_inv_input_sel,
  input wire logic [3:0] cmp_b_inv_input_sel,
  input wire logic cmp_a_pin_oe,
  input wire logic cmp_b_pin_oe,
  input wire logic cmp_b_sync_result
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer");
  unmapped_read_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  mirror_zero_a: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata[5:1] == 5'h00)
    else $error("mirror register unused bits set");
  a_write_a: assert property (reg_wr && reg_addr == 2'h0 |=>
    {cmp_a_on, cmp_a_speed_sel, cmp_a_ref_sel} == $past({reg_wdata[7], reg_wdata[3:2]}))
    else $error("comparator a controls not written");
  b_write_a: assert property (reg_wr && reg_addr == 2'h1 |=>
    {cmp_b_on, cmp_b_speed_sel, cmp_b_ref_sel} == $past({reg_wdata[7], reg_wdata[3:2]}))
    else $error("comparator b controls not written");
  a_hold_a: assert property (!(reg_wr && reg_addr == 2'h0) |=>
    $stable({cmp_a_on, cmp_a_speed_sel, cmp_a_ref_sel}))
    else $error("comparator a controls changed without write");
  a_readback_a: assert property (reg_rd && reg_addr == 2'h0 |=>
    {reg_rdata[7], reg_rdata[3:2]} == $past({cmp_a_on, cmp_a_speed_sel, cmp_a_ref_sel}))
    else $error("comparator a readback differs");
  sel_onehot_a: assert property ($onehot(cmp_a_inv_input_sel) && $onehot(cmp_b_inv_input_sel))
    else $error("input select not one-hot");
  a_pin_gate_a: assert property (cmp_a_pin_oe |-> cmp_a_on || $past(cmp_a_on))
    else $error("pin a driven while disabled");
  b_pin_gate_a: assert property (cmp_b_pin_oe |-> cmp_b_on || $past(cmp_b_on))
    else $error("pin b driven while disabled");
  sync_edge_a: assert property ($changed(cmp_b_sync_result) |->
    !($past(timer_clk_prescaled, 2) && $past(timer_clk_prescaled, 3) && $past(timer_clk_prescaled, 4)))
    else $error("synced result moved away from falling edge");
endmodule : dcc_assertions
bind dcc_top dcc_assertions dcc_assertions_inst (.clk_sys(clk_sys), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .timer_clk_prescaled(timer_clk_prescaled), .cmp_a_on(cmp_a_on),
  .cmp_b_on(cmp_b_on), .cmp_a_speed_sel(cmp_a_speed_sel), .cmp_b_speed_sel(cmp_b_speed_sel),
  .cmp_a_ref_sel(cmp_a_ref_sel), .cmp_b_ref_sel(cmp_b_ref_sel),
  .cmp_a_inv_input_sel(cmp_a_inv_input_sel), .cmp_b_inv_input_sel(cmp_b_inv_input_sel),
  .cmp_a_pin_oe(cmp_a_pin_oe), .cmp_b_pin_oe(cmp_b_pin_oe),
  .cmp_b_sync_result(cmp_b_sync_result));

//--- verif/dual_comparator_control_test.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "dcc_cfg.svh"
module dual_comparator_control_test;
  import dcc_pkg::*;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic [`DCC_ADDR_W-1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0, reg_rd = 1'h0, cmp_a_raw = 1'h0, cmp_b_raw = 1'h0;
  logic timer_clk_prescaled = 1'h0, port_a_direction_bit2 = 1'h1, port_c_direction_bit4 = 1'h1;
  logic [7:0] reg_rdata;
  logic [3:0] cmp_a_inv_input_sel, cmp_b_inv_input_sel;
  logic cmp_a_on, cmp_b_on, cmp_a_speed_sel, cmp_b_speed_sel, cmp_a_ref_sel, cmp_b_ref_sel;
  logic cmp_a_pin_out, cmp_a_pin_oe, cmp_b_pin_out, cmp_b_pin_oe, cmp_b_sync_result;
  logic cmp_a_change, cmp_b_change;
  int n_errors = 0, checked = 0, na = 0, nb = 0;
  integer seed = 32'h1206;

  dcc_top dcc_top_inst (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .timer_clk_prescaled(timer_clk_prescaled),
    .port_a_direction_bit2(port_a_direction_bit2),
    .port_c_direction_bit4(port_c_direction_bit4), .cmp_a_on(cmp_a_on), .cmp_b_on(cmp_b_on),
    .cmp_a_speed_sel(cmp_a_speed_sel), .cmp_b_speed_sel(cmp_b_speed_sel),
    .cmp_a_ref_sel(cmp_a_ref_sel), .cmp_b_ref_sel(cmp_b_ref_sel),
    .cmp_a_inv_input_sel(cmp_a_inv_input_sel), .cmp_b_inv_input_sel(cmp_b_inv_input_sel),
    .cmp_a_pin_out(cmp_a_pin_out), .cmp_a_pin_oe(cmp_a_pin_oe), .cmp_b_pin_out(cmp_b_pin_out),
    .cmp_b_pin_oe(cmp_b_pin_oe), .cmp_b_sync_result(cmp_b_sync_result),
    .cmp_a_change(cmp_a_change), .cmp_b_change(cmp_b_change));

  always #4 clk_sys = ~clk_sys;
  // Timer edges kept off the system clock edges
  initial begin
    #3;
    forever #96 timer_clk_prescaled = ~timer_clk_prescaled;
  end
  always @(posedge clk_sys) begin
    if (cmp_a_change === 1'h1) na <= na + 1;
    if (cmp_b_change === 1'h1) nb <= nb + 1;
  end

  function automatic logic res(logic [7:0] c, logic r);
    return (r & c[7]) ^ c[4];
  endfunction : res
  function automatic logic [8:0] outs(logic [7:0] c, logic r, logic dir);
    logic oe;
    oe = c[5] & c[7] & !dir;
    return {res(c, r) | !oe, c[7], c[3], c[2], oe, 4'h1 << c[1:0]};
  endfunction : outs

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 chk(what, {1'h0, exp}, {1'h0, reg_rdata});
    @(posedge clk_sys);
  endtask : rdchk
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin : main
    logic [7:0] da, db, oa, ob, q;
    logic ra, rb, pa, pb;
    int ea, eb;
    oa = 8'h00;
    ob = 8'h00;
    ra = 1'h0;
    rb = 1'h0;
    ea = 0;
    eb = 0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rdchk(i[1:0], 8'h00, "reset reg");
    chk("reset outs a", outs(8'h00, 1'h0, 1'h1), {cmp_a_pin_out | !cmp_a_pin_oe, cmp_a_on,
      cmp_a_speed_sel, cmp_a_ref_sel, cmp_a_pin_oe, cmp_a_inv_input_sel});
    chk("reset outs b", outs(8'h00, 1'h0, 1'h1), {cmp_b_pin_out | !cmp_b_pin_oe, cmp_b_on,
      cmp_b_speed_sel, cmp_b_ref_sel, cmp_b_pin_oe, cmp_b_inv_input_sel});
    chk("reset changes", 9'h000, 9'(na + nb));
    chk("reset sync out", 9'h000, {8'h00, cmp_b_sync_result});
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      da = 8'($random(seed));
      db = 8'($random(seed));
      q = 8'($random(seed));
      // Corner: all channel codes with both comparators on
      if (i < 4) begin
        da = {1'h1, da[6:2], i[1:0]};
        db = {1'h1, db[6:2], ~i[1:0]};
      end
      ea += int'(res(oa, q[0]) != res(oa, ra));
      eb += int'(res(ob, q[1]) != res(ob, rb));
      ra = q[0];
      rb = q[1];
      pa = q[2];
      pb = q[3];
      cmp_a_raw <= ra;
      cmp_b_raw <= rb;
      port_a_direction_bit2 <= pa;
      port_c_direction_bit4 <= pb;
      repeat (6) @(posedge clk_sys);
      wr(2'h0, da);
      wr(2'h1, db);
      wr(2'h2, q & 8'hFE);
      wr(2'h3, q);
      repeat (6) @(posedge clk_sys);
      ea += int'(res(da, ra) != res(oa, ra));
      eb += int'(res(db, rb) != res(ob, rb));
      oa = da;
      ob = db;
      rdchk(2'h0, {da[7], res(da, ra), da[5:0]}, "ctrl a");
      rdchk(2'h1, {db[7], res(db, rb), db[5:0]}, "ctrl b");
      rdchk(2'h2, {res(da, ra), res(db, rb), 6'h00}, "mirror");
      rdchk(2'h3, 8'h00, "unmapped");
      chk("outs a", outs(da, ra, pa), {cmp_a_pin_out | !cmp_a_pin_oe, cmp_a_on,
        cmp_a_speed_sel, cmp_a_ref_sel, cmp_a_pin_oe, cmp_a_inv_input_sel});
      chk("outs b", outs(db, rb, pb), {cmp_b_pin_out | !cmp_b_pin_oe, cmp_b_on,
        cmp_b_speed_sel, cmp_b_ref_sel, cmp_b_pin_oe, cmp_b_inv_input_sel});
      chk("changes a", 9'(ea), 9'(na));
      chk("changes b", 9'(eb), 9'(nb));
    end
    $display("test random done");
    wr(2'h2, 8'hFF);
    wr(2'h1, 8'h80);
    cmp_b_raw <= 1'h0;
    repeat (2) @(negedge timer_clk_prescaled);
    repeat (4) @(posedge clk_sys);
    cmp_b_raw <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rdchk(2'h2, {res(oa, ra), 7'h41}, "sync hold");
    chk("sync hold", 9'h000, {8'h00, cmp_b_sync_result});
    eb = nb + 1;
    @(negedge timer_clk_prescaled);
    repeat (5) @(posedge clk_sys);
    rdchk(2'h2, {res(oa, ra), 7'h41}, "sync take");
    chk("sync out", 9'h001, {8'h00, cmp_b_sync_result});
    chk("sync change", 9'(eb), 9'(nb));
    $display("test sync done");
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) rdchk(i[1:0], 8'h00, "second reset");
    chk("second reset outs a", outs(8'h00, 1'h0, 1'h1), {cmp_a_pin_out | !cmp_a_pin_oe,
      cmp_a_on, cmp_a_speed_sel, cmp_a_ref_sel, cmp_a_pin_oe, cmp_a_inv_input_sel});
    chk("second reset outs b", outs(8'h00, 1'h0, 1'h1), {cmp_b_pin_out | !cmp_b_pin_oe,
      cmp_b_on, cmp_b_speed_sel, cmp_b_ref_sel, cmp_b_pin_oe, cmp_b_inv_input_sel});
    chk("second reset sync out", 9'h000, {8'h00, cmp_b_sync_result});
    $display("test second reset done");
    conclude();
  end
endmodule : dual_comparator_control_test
